// ==== srst_top.v ====
// System reset control: reset source flags, software reset bits and protection
`timescale 1ns/1ns
`include "srst_defs.vh"

module srst_top
#(
	// Part identification value, arbitrary
	parameter [`SRST_DATA_W-1:0] PART_ID = 32'h00c0ffee
)
(
	// Clock and power-on reset
	input  wire                     clock_i,
	input  wire                     rst_n_i,
	// Register port
	input  wire [`SRST_ADDR_W-1:0]  reg_addr_i,
	input  wire [`SRST_DATA_W-1:0]  reg_wdata_i,
	input  wire                     reg_write_i,
	input  wire                     reg_read_i,
	output wire [`SRST_DATA_W-1:0]  reg_rdata_o,
	// Reset events from the rest of the chip
	input  wire                     core_system_reset_request_i,
	input  wire                     brownout_reset_i,
	input  wire                     low_voltage_reset_i,
	input  wire                     watchdog_reset_i,
	input  wire                     window_watchdog_reset_i,
	input  wire                     external_reset_pin_n_i,
	// Reset outputs to controllers
	output wire                     bus_interface_reset_o,
	output wire                     dma_reset_n_o,
	output wire                     cpu_reset_o,
	output wire                     flash_memory_controller_reset_o,
	output wire                     chip_reset_o,
	output wire                     system_reset_o,
	output wire                     crystal_boot_select_reset_o,
	output wire                     config_reload_o,
	output wire [`SRST_DATA_W-1:0]  peripheral_reset_two_o,
	output wire [`SRST_PER3_W-1:0]  peripheral_reset_three_o,
	// Protection status
	output wire                     protection_open_o
);

	// Address decode
	wire sel_part_id;
	wire sel_source;
	wire sel_core_ctrl;
	wire sel_per_two;
	wire sel_per_three;
	wire sel_unlock;

	assign sel_part_id   = (reg_addr_i == `SRST_OFF_PART_ID);
	assign sel_source    = (reg_addr_i == `SRST_OFF_SOURCE);
	assign sel_core_ctrl = (reg_addr_i == `SRST_OFF_CORE_CTRL);
	assign sel_per_two   = (reg_addr_i == `SRST_OFF_PERIPH_TWO);
	assign sel_per_three = (reg_addr_i == `SRST_OFF_PERIPH_THREE);
	assign sel_unlock    = (reg_addr_i == `SRST_OFF_UNLOCK);

	// Write strobes per register
	wire wr_source;
	wire wr_core_ctrl;
	wire wr_per_two;
	wire wr_per_three;
	wire wr_unlock;

	assign wr_source    = reg_write_i & sel_source;
	assign wr_per_two   = reg_write_i & sel_per_two;
	assign wr_per_three = reg_write_i & sel_per_three;
	assign wr_unlock    = reg_write_i & sel_unlock;

	// Protection sequencer
	wire unlocked;

	srst_unlock u_unlock
	(
		.clock_i     (clock_i),
		.rst_n_i     (rst_n_i),
		.key_write_i (wr_unlock),
		.key_i       (reg_wdata_i[`SRST_KEY_W-1:0]),
		.open_o      (unlocked)
	);

	// Protected register only takes writes while unlocked
	assign wr_core_ctrl = reg_write_i & sel_core_ctrl & unlocked;

	// Core and system reset control: level bits
	reg bus_if_rst_q;
	reg dma_rst_q;

	always @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			bus_if_rst_q <= 1'b0;
			dma_rst_q    <= 1'b0;
		end
		else if (wr_core_ctrl)
		begin
			bus_if_rst_q <= reg_wdata_i[`SRST_CTL_BUS_IF];
			dma_rst_q    <= reg_wdata_i[`SRST_CTL_DMA];
		end
	end

	// Self-clearing one-shot bits: index 0 chip, index 1 CPU
	wire [1:0] oneshot_start;
	wire [1:0] oneshot_bit;

	assign oneshot_start[0] = wr_core_ctrl & reg_wdata_i[`SRST_CTL_CHIP];
	assign oneshot_start[1] = wr_core_ctrl & reg_wdata_i[`SRST_CTL_CPU];

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi = gi + 1)
		begin : g_oneshot
			reg                   bit_q;
			reg [`SRST_CNT_W-1:0] cnt_q;

			// Hold the bit for the one-shot length, then drop it
			always @(posedge clock_i or negedge rst_n_i)
			begin
				if (!rst_n_i)
				begin
					bit_q <= 1'b0;
					cnt_q <= {`SRST_CNT_W{1'b0}};
				end
				else if (oneshot_start[gi])
				begin
					bit_q <= 1'b1;
					cnt_q <= {`SRST_CNT_W{1'b0}};
				end
				else if (bit_q)
				begin
					if (cnt_q == `SRST_ONESHOT_CYCLES - 2'h1)
						bit_q <= 1'b0;
					else
						cnt_q <= cnt_q + 2'h1;
				end
			end

			assign oneshot_bit[gi] = bit_q;
		end
	endgenerate

	// Peripheral reset registers, unprotected
	reg [`SRST_DATA_W-1:0] per_two_q;
	reg [`SRST_PER3_W-1:0] per_three_q;

	always @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			per_two_q   <= `SRST_PER2_RESET;
			per_three_q <= `SRST_PER3_RESET;
		end
		else
		begin
			if (wr_per_two)
				per_two_q <= reg_wdata_i & `SRST_PER2_MASK;
			if (wr_per_three)
				per_three_q <= reg_wdata_i[`SRST_PER3_W-1:0] & `SRST_PER3_MASK;
		end
	end

	// Reset source event collection
	wire [`SRST_SRC_W-1:0] src_set;
	wire [`SRST_SRC_W-1:0] src_clr;

	assign src_set[`SRST_SRC_CPU] = oneshot_start[1];
	assign src_set[6]             = 1'b0;
	assign src_set[`SRST_SRC_SYS] = core_system_reset_request_i;
	assign src_set[`SRST_SRC_BOD] = brownout_reset_i;
	assign src_set[`SRST_SRC_LVR] = low_voltage_reset_i;
	assign src_set[`SRST_SRC_WDT] = watchdog_reset_i | window_watchdog_reset_i;
	assign src_set[`SRST_SRC_PIN] = ~external_reset_pin_n_i;
	assign src_set[`SRST_SRC_POR] = oneshot_start[0];

	assign src_clr = wr_source ? reg_wdata_i[`SRST_SRC_W-1:0] : {`SRST_SRC_W{1'b0}};

	// Sticky flags; a set in the clearing cycle wins
	reg [`SRST_SRC_W-1:0] src_q;
	reg [`SRST_SRC_W-1:0] src_d;

	always @*
	begin
		src_d = ((src_q & ~src_clr) | src_set) & `SRST_SRC_MASK;
	end

	// Power-on leaves only the power-on flag standing
	always @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			src_q <= `SRST_SRC_RESET;
		else
			src_q <= src_d;
	end

	// Registered reset outputs
	reg cpu_rst_q;
	reg fmc_rst_q;
	reg chip_rst_q;
	reg sys_rst_q;
	reg xtal_rst_q;
	reg reload_q;

	always @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			cpu_rst_q  <= 1'b0;
			fmc_rst_q  <= 1'b0;
			chip_rst_q <= 1'b0;
			sys_rst_q  <= 1'b0;
			xtal_rst_q <= 1'b0;
			reload_q   <= 1'b0;
		end
		else
		begin
			// CPU one-shot reaches core and flash controller only
			cpu_rst_q  <= oneshot_bit[1] | oneshot_bit[0];
			fmc_rst_q  <= oneshot_bit[1] | oneshot_bit[0];
			chip_rst_q <= oneshot_bit[0];
			// Whole-chip reset from every system-level source
			sys_rst_q  <= oneshot_bit[0] | core_system_reset_request_i
			              | brownout_reset_i | low_voltage_reset_i
			              | watchdog_reset_i | window_watchdog_reset_i
			              | ~external_reset_pin_n_i;
			// Crystal and boot select reset only on power-on style reset
			xtal_rst_q <= oneshot_bit[0];
			reload_q   <= oneshot_bit[0];
		end
	end

	assign cpu_reset_o                     = cpu_rst_q;
	assign flash_memory_controller_reset_o = fmc_rst_q;
	assign chip_reset_o                    = chip_rst_q;
	assign system_reset_o                  = sys_rst_q;
	assign crystal_boot_select_reset_o     = xtal_rst_q;
	assign config_reload_o                 = reload_q;
	assign bus_interface_reset_o           = bus_if_rst_q;
	assign dma_reset_n_o                   = ~dma_rst_q;
	assign peripheral_reset_two_o          = per_two_q;
	assign peripheral_reset_three_o        = per_three_q;
	assign protection_open_o               = unlocked;

	// Read multiplexer; unmapped addresses read zero
	reg [`SRST_DATA_W-1:0] rdata_d;

	always @*
	begin
		rdata_d = {`SRST_DATA_W{1'b0}};
		if (sel_part_id)
			rdata_d = PART_ID;
		else if (sel_source)
			rdata_d = {{(`SRST_DATA_W-`SRST_SRC_W){1'b0}}, src_q};
		else if (sel_core_ctrl)
			rdata_d = {28'h0000000, bus_if_rst_q, dma_rst_q, oneshot_bit[1], oneshot_bit[0]};
		else if (sel_per_two)
			rdata_d = per_two_q;
		else if (sel_per_three)
			rdata_d = {{(`SRST_DATA_W-`SRST_PER3_W){1'b0}}, per_three_q};
		else if (sel_unlock)
			rdata_d = {31'h00000000, unlocked};
	end

	// Read data stand for one cycle after the strobe
	reg [`SRST_DATA_W-1:0] rdata_q;

	always @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			rdata_q <= {`SRST_DATA_W{1'b0}};
		else if (reg_read_i)
			rdata_q <= rdata_d;
		else
			rdata_q <= {`SRST_DATA_W{1'b0}};
	end

	assign reg_rdata_o = rdata_q;

endmodule

// ==== srst_defs.vh ====
// Constants of the system reset control block: offsets, bit positions, masks, timing
`ifndef SRST_DEFS_VH
`define SRST_DEFS_VH

// Register bus geometry
`define SRST_ADDR_W            12
`define SRST_DATA_W            32

// Register byte offsets
`define SRST_OFF_PART_ID       12'h000
`define SRST_OFF_SOURCE        12'h004
`define SRST_OFF_CORE_CTRL     12'h008
`define SRST_OFF_PERIPH_TWO    12'h00c
`define SRST_OFF_PERIPH_THREE  12'h010
`define SRST_OFF_UNLOCK        12'h100

// Reset source flag positions
`define SRST_SRC_CPU           7
`define SRST_SRC_SYS           5
`define SRST_SRC_BOD           4
`define SRST_SRC_LVR           3
`define SRST_SRC_WDT           2
`define SRST_SRC_PIN           1
`define SRST_SRC_POR           0
`define SRST_SRC_W             8
`define SRST_SRC_MASK          8'hbf
`define SRST_SRC_RESET         8'h01

// Core and system reset control positions
`define SRST_CTL_BUS_IF        3
`define SRST_CTL_DMA           2
`define SRST_CTL_CPU           1
`define SRST_CTL_CHIP          0

// Peripheral reset register widths, masks and reset values
`define SRST_PER2_MASK         32'h3bf7f33e
`define SRST_PER3_W            3
`define SRST_PER3_MASK         3'h7
`define SRST_PER2_RESET        32'h00000000
`define SRST_PER3_RESET        3'h0

// Unlock key sequence
`define SRST_KEY_W             8
`define SRST_KEY_FIRST         8'h59
`define SRST_KEY_SECOND        8'h16
`define SRST_KEY_THIRD         8'h88

// One-shot reset length in clock cycles
`define SRST_ONESHOT_CYCLES    2'h2
`define SRST_CNT_W             2

`endif

// ==== srst_unlock.v ====
// Write protection unlock sequencer of the system reset control block
`timescale 1ns/1ns
`include "srst_defs.vh"

module srst_unlock
(
	// Clock and reset
	input  wire                    clock_i,
	input  wire                    rst_n_i,
	// Key writes
	input  wire                    key_write_i,
	input  wire [`SRST_KEY_W-1:0]  key_i,
	// Protection state
	output wire                    open_o
);

	localparam [3:0] ST_LOCKED = 4'h1;
	localparam [3:0] ST_FIRST  = 4'h2;
	localparam [3:0] ST_SECOND = 4'h4;
	localparam [3:0] ST_OPEN   = 4'h8;

	reg [3:0] state_q;
	reg [3:0] state_d;

	// Key sequence: a wrong byte restarts, a first key byte rearms
	always @*
	begin
		state_d = state_q;
		if (key_write_i)
		begin
			case (state_q)
				ST_LOCKED:
					state_d = (key_i == `SRST_KEY_FIRST) ? ST_FIRST : ST_LOCKED;
				ST_FIRST:
					if (key_i == `SRST_KEY_SECOND)
						state_d = ST_SECOND;
					else
						state_d = (key_i == `SRST_KEY_FIRST) ? ST_FIRST : ST_LOCKED;
				ST_SECOND:
					if (key_i == `SRST_KEY_THIRD)
						state_d = ST_OPEN;
					else
						state_d = (key_i == `SRST_KEY_FIRST) ? ST_FIRST : ST_LOCKED;
				ST_OPEN:
					state_d = ST_LOCKED; // Any write while open relocks
				default:
					state_d = ST_LOCKED;
			endcase
		end
	end

	// State register, locked after reset
	always @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			state_q <= ST_LOCKED;
		else
			state_q <= state_d;
	end

	assign open_o = (state_q == ST_OPEN);

endmodule

// ==== srst_chk_assertions.sv ====
// Port assertions of the system reset control block
`timescale 1ns/1ns
`include "srst_defs.vh"

module srst_chk
#(
	parameter [`SRST_DATA_W-1:0] PART_ID = 32'h0
)
(
	// Clock, reset and register port
	input wire			clock_i,
	input wire			rst_n_i,
	input wire [`SRST_ADDR_W-1:0]	reg_addr_i,
	input wire [`SRST_DATA_W-1:0]	reg_wdata_i,
	input wire			reg_write_i,
	input wire			reg_read_i,
	input wire [`SRST_DATA_W-1:0]	reg_rdata_o,
	// Reset events
	input wire			core_system_reset_request_i,
	input wire			external_reset_pin_n_i,
	// Reset outputs and protection
	input wire			bus_interface_reset_o,
	input wire			dma_reset_n_o,
	input wire			cpu_reset_o,
	input wire			chip_reset_o,
	input wire			system_reset_o,
	input wire			config_reload_o,
	input wire			protection_open_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);

	// Write to the core and system reset control register
	wire ctl_wr = reg_write_i && reg_addr_i == `SRST_OFF_CORE_CTRL;

	// Identification read answers in the next cycle
	property p_part_id;
		reg_read_i && reg_addr_i == `SRST_OFF_PART_ID |=> reg_rdata_o == PART_ID;
	endproperty
	a_part_id: assert property (p_part_id) else $error("part id read wrong");

	// Level resets move only after a control write
	property p_held;
		!ctl_wr |=> $stable(bus_interface_reset_o) && $stable(dma_reset_n_o);
	endproperty
	a_held: assert property (p_held) else $error("held reset moved");

	// CPU one-shot lasts two cycles
	property p_cpu_pulse;
		$rose(cpu_reset_o) |-> cpu_reset_o[*2] ##1 !cpu_reset_o;
	endproperty
	a_cpu_pulse: assert property (p_cpu_pulse) else $error("cpu pulse length");

	// Chip one-shot lasts two cycles and reloads settings
	property p_chip_pulse;
		$rose(chip_reset_o) |-> config_reload_o && chip_reset_o ##1 chip_reset_o ##1 !chip_reset_o;
	endproperty
	a_chip_pulse: assert property (p_chip_pulse) else $error("chip pulse wrong");

	// Unlocked CPU one-shot write reaches the core
	property p_cpu_start;
		ctl_wr && reg_wdata_i[`SRST_CTL_CPU] && protection_open_o |-> ##2 cpu_reset_o;
	endproperty
	a_cpu_start: assert property (p_cpu_start) else $error("cpu reset missing");

	// Locked control writes change nothing
	property p_locked;
		ctl_wr && !protection_open_o |-> ##1 $stable(bus_interface_reset_o) ##1 !cpu_reset_o && !chip_reset_o;
	endproperty
	a_locked: assert property (p_locked) else $error("locked write acted");

	// Core request and pin reset drive the system reset
	property p_sys;
		core_system_reset_request_i || !external_reset_pin_n_i |=> system_reset_o;
	endproperty
	a_sys: assert property (p_sys) else $error("system reset missing");

	// A write to the unlock register while open locks again
	property p_relock;
		reg_write_i && reg_addr_i == `SRST_OFF_UNLOCK && protection_open_o |=> !protection_open_o;
	endproperty
	a_relock: assert property (p_relock) else $error("relock failed");
endmodule

bind srst_top srst_chk #(.PART_ID(PART_ID)) i_chk (
	.clock_i(clock_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
	.reg_write_i(reg_write_i), .reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o),
	.core_system_reset_request_i(core_system_reset_request_i), .external_reset_pin_n_i(external_reset_pin_n_i),
	.bus_interface_reset_o(bus_interface_reset_o), .dma_reset_n_o(dma_reset_n_o), .cpu_reset_o(cpu_reset_o),
	.chip_reset_o(chip_reset_o), .system_reset_o(system_reset_o), .config_reload_o(config_reload_o),
	.protection_open_o(protection_open_o)
);

// ==== tb.sv ====
// Self-checking testbench of the system reset control block
`timescale 1ns/1ns
`include "srst_defs.vh"
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin miscompares++; $display("BAD %s exp %h got %h", n, e, s); end end

module tb;
	localparam [31:0] PID = 32'h5a5a0001; // Arbitrary identification value
	reg		clock_i, rst_n_i, w, r;
	reg [11:0]	a;
	reg [31:0]	d, v;
	reg [5:0]	ev;
	wire [31:0]	rdata, per2;
	wire [2:0]	per3;
	wire		bus_rst, dma_n, cpu_rst, open;
	wire		fmc_rst, chip_rst, sys_rst, xtal_rst, reload;
	integer		seed = 71, checks = 0, miscompares = 0, cyc = 0, i;

	srst_top #(.PART_ID(PID)) i_dut (
		.clock_i(clock_i), .rst_n_i(rst_n_i), .reg_addr_i(a), .reg_wdata_i(d),
		.reg_write_i(w), .reg_read_i(r), .reg_rdata_o(rdata),
		.core_system_reset_request_i(ev[5]), .brownout_reset_i(ev[1]), .low_voltage_reset_i(ev[2]),
		.watchdog_reset_i(ev[3]), .window_watchdog_reset_i(ev[4]), .external_reset_pin_n_i(!ev[0]),
		.bus_interface_reset_o(bus_rst), .dma_reset_n_o(dma_n), .cpu_reset_o(cpu_rst),
		.flash_memory_controller_reset_o(fmc_rst), .chip_reset_o(chip_rst), .system_reset_o(sys_rst),
		.crystal_boot_select_reset_o(xtal_rst), .config_reload_o(reload),
		.peripheral_reset_two_o(per2), .peripheral_reset_three_o(per3), .protection_open_o(open)
	);

	// Flag expected from each event input
	function [31:0] flag_of(input integer k);
		case (k)
			0: flag_of = 32'h02;
			1: flag_of = 32'h10;
			2: flag_of = 32'h08;
			3, 4: flag_of = 32'h04;
			default: flag_of = 32'h20;
		endcase
	endfunction

	task conclude;
		begin
			$display("checks %0d miscompares %0d", checks, miscompares);
			if (miscompares == 0 && checks > 0)
				$display("Testbench passed");
			else
				$display("Testbench failed");
			$finish;
		end
	endtask

	// One-cycle write; the strobe stays up for a following write
	task wr(input [11:0] ad, input [31:0] dt);
		begin
			r <= 1'b0;
			w <= 1'b1;
			a <= ad;
			d <= dt;
			@(posedge clock_i);
		end
	endtask

	task idle;
		begin
			w <= 1'b0;
			r <= 1'b0;
			@(posedge clock_i);
		end
	endtask

	// Read, then compare the data of the following cycle
	task rd(input [11:0] ad, input [31:0] ex);
		begin
			w <= 1'b0;
			r <= 1'b1;
			a <= ad;
			@(posedge clock_i);
			r <= 1'b0;
			@(negedge clock_i);
			`CHK("rdata", ex, rdata)
			@(posedge clock_i);
		end
	endtask

	// One-cycle pulse on one event input
	task pulse(input integer k);
		begin
			w <= 1'b0;
			ev <= 6'h01 << k;
			@(posedge clock_i);
			ev <= 6'h00;
			@(posedge clock_i);
		end
	endtask

	// Clock of 4 ns
	initial
	begin
		clock_i = 1'b0;
		forever #2 clock_i = ~clock_i;
	end

	// Hang guard
	always @(posedge clock_i)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			miscompares++;
			conclude;
		end
	end

	initial
	begin
		rst_n_i = 1'b0;
		{w, r, a, d, ev} = 0;
		repeat (20) @(posedge clock_i);
		rst_n_i <= 1'b1;
		@(posedge clock_i);
		wr(`SRST_OFF_PART_ID, 32'hffffffff);
		rd(`SRST_OFF_PART_ID, PID);
		rd(`SRST_OFF_SOURCE, 32'h01);
		rd(`SRST_OFF_CORE_CTRL, 32'h0);
		rd(`SRST_OFF_PERIPH_TWO, 32'h0);
		rd(`SRST_OFF_PERIPH_THREE, 32'h0);
		rd(`SRST_OFF_UNLOCK, 32'h0);
		rd(12'h020, 32'h0);
		wr(`SRST_OFF_SOURCE, 32'h0);
		rd(`SRST_OFF_SOURCE, 32'h01);
		wr(`SRST_OFF_SOURCE, 32'h01);
		rd(`SRST_OFF_SOURCE, 32'h0);
		for (i = 0; i < 6; i++)
		begin
			pulse(i);
			`CHK("xtal", 1'b0, xtal_rst)
			`CHK("reload", 1'b0, reload)
			rd(`SRST_OFF_SOURCE, flag_of(i));
			wr(`SRST_OFF_SOURCE, flag_of(i));
		end
		wr(`SRST_OFF_CORE_CTRL, 32'h0f);
		rd(`SRST_OFF_CORE_CTRL, 32'h0);
		rd(`SRST_OFF_SOURCE, 32'h0);
		wr(`SRST_OFF_UNLOCK, 32'h59);
		wr(`SRST_OFF_UNLOCK, 32'h16);
		wr(`SRST_OFF_UNLOCK, 32'h88);
		idle;
		`CHK("open", 1'b1, open)
		rd(`SRST_OFF_UNLOCK, 32'h1);
		wr(`SRST_OFF_CORE_CTRL, 32'h0c);
		rd(`SRST_OFF_CORE_CTRL, 32'h0c);
		`CHK("bus_rst", 1'b1, bus_rst)
		`CHK("dma_n", 1'b0, dma_n)
		wr(`SRST_OFF_CORE_CTRL, 32'h0e);
		rd(`SRST_OFF_SOURCE, 32'h80);
		`CHK("cpu_rst", 1'b1, cpu_rst)
		`CHK("fmc_rst", 1'b1, fmc_rst)
		`CHK("chip_rst", 1'b0, chip_rst)
		`CHK("xtal", 1'b0, xtal_rst)
		rd(`SRST_OFF_CORE_CTRL, 32'h0c);
		wr(`SRST_OFF_CORE_CTRL, 32'h01);
		rd(`SRST_OFF_SOURCE, 32'h81);
		`CHK("chip_rst", 1'b1, chip_rst)
		`CHK("sys_rst", 1'b1, sys_rst)
		`CHK("xtal", 1'b1, xtal_rst)
		`CHK("reload", 1'b1, reload)
		`CHK("fmc_rst", 1'b1, fmc_rst)
		rd(`SRST_OFF_CORE_CTRL, 32'h0);
		`CHK("bus_rst", 1'b0, bus_rst)
		`CHK("dma_n", 1'b1, dma_n)
		wr(`SRST_OFF_UNLOCK, 32'h0);
		wr(`SRST_OFF_UNLOCK, 32'h59);
		wr(`SRST_OFF_UNLOCK, 32'h17);
		wr(`SRST_OFF_UNLOCK, 32'h88);
		idle;
		`CHK("open", 1'b0, open)
		wr(`SRST_OFF_CORE_CTRL, 32'h02);
		rd(`SRST_OFF_SOURCE, 32'h81);
		for (i = 0; i < 8; i++)
		begin
			v = (i == 0) ? 32'hffffffff : $random(seed);
			wr(`SRST_OFF_PERIPH_TWO, v);
			rd(`SRST_OFF_PERIPH_TWO, v & `SRST_PER2_MASK);
			`CHK("per2", v & `SRST_PER2_MASK, per2)
			wr(`SRST_OFF_PERIPH_THREE, v);
			rd(`SRST_OFF_PERIPH_THREE, v & 32'h7);
			`CHK("per3", v[2:0], per3)
		end
		rst_n_i <= 1'b0;
		@(posedge clock_i);
		rst_n_i <= 1'b1;
		@(posedge clock_i);
		rd(`SRST_OFF_SOURCE, 32'h01);
		rd(`SRST_OFF_PERIPH_TWO, 32'h0);
		conclude;
	end
endmodule
